// >>> sebs_pkg.sv
// Shared constants and types for the two-wire EEPROM slave and its bus master.
// Assumes one 100 MHz system clock for both ends and an open-drain bus resolved in sebs_bus_if.
// Contract
// R1 - Addressed device acknowledges every received byte
// R2 - Master adds ninth clock for acknowledge
// R3 - No acknowledge at all while programming
// R4 - Acknowledger holds data low whole high phase
// R5 - Master nack ends read; device releases data
// R6 - First byte after Start is control byte
// R7 - Chip-select bits must equal select pins
// R8 - Eighth control bit one reads, zero writes
// R9 - Write: second byte loads address pointer
// R10 - Stop after data starts write cycle
// R11 - Protected write acknowledged, memory unchanged, timed
// R12 - Up to sixteen page bytes, committed on Stop
// R13 - Page bytes step low nibble only, wrapping
// R14 - Master avoids crossing a page boundary; sebs_master does not enforce it and the testbench overruns a page
// R15 - Poll with write control byte until acknowledged
// R16 - Bare read returns byte at pointer
// R17 - Repeated Start aborts write, keeps pointer
// R18 - Master acknowledge fetches next sequential byte
// R19 - Pointer increments after each byte
// R20 - Write cycle ends within five milliseconds
// R21 - Protect pin high blocks every write
// R22 - Eight-bit pointer wraps top to zero
// R23 - Mismatched control byte ignored until Start
package sebs_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int WRITE_CYCLE_MS = 5;
    // Longest time, so rounded down
    localparam int WRITE_CYCLE_CYC = CLK_HZ / 1000 * WRITE_CYCLE_MS;
    localparam int SCL_HZ = 400_000;
    // Least quarter period, so rounded up
    localparam int SCL_QUARTER_CYC = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
    // Arbitrary value for the memory access control code
    localparam logic [3:0] DEV_CODE = 4'h5;
    localparam int ADDR_W = 8;
    localparam int PAGE_W = 4;
    localparam int PAGE_SIZE = 16;
    localparam int AXI_ADDR_W = 4;
    localparam logic [AXI_ADDR_W-1:0] CMD_OFF = 4'h0;
    localparam logic [AXI_ADDR_W-1:0] STATUS_OFF = 4'h4;
    localparam int CMD_START_BIT = 0;
    localparam int CMD_WRITE_BIT = 1;
    localparam int CMD_READ_BIT = 2;
    localparam int CMD_STOP_BIT = 3;
    localparam int CMD_NACK_BIT = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] ROLE_CTRL = 2'h0;
    localparam logic [1:0] ROLE_ADDR = 2'h1;
    localparam logic [1:0] ROLE_DATA = 2'h2;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_RX_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_TX_ACK = 5'h10
    } sebs_dev_state_t;
    typedef enum logic [3:0] {
        M_IDLE = 4'h1,
        M_START = 4'h2,
        M_BIT = 4'h4,
        M_STOP = 4'h8
    } sebs_mst_state_t;
endpackage : sebs_pkg

// >>> sebs_bus_if.sv
// Two-wire bus between the master and the EEPROM slave.
// Assumes both ends only pull low; a released line reads high.
`timescale 1ns/1ns
interface sebs_bus_if;
    logic scl_oe_mst;
    logic sda_oe_mst;
    logic sda_oe_dev;
    logic scl;
    logic sda;
    assign scl = ~scl_oe_mst;
    assign sda = ~(sda_oe_mst | sda_oe_dev);
    modport master (output scl_oe_mst, output sda_oe_mst, input scl, input sda);
    modport eeprom (output sda_oe_dev, input scl, input sda);
endinterface : sebs_bus_if

// >>> sebs_eeprom.sv
// EEPROM slave end: 256 bytes, 16-byte page buffer, self-timed write cycle.
// Assumes a master that drives the clock; bus pins arrive asynchronously and are synchronised.
//
// Design decisions made here: page commit one byte per clock at the start of the write cycle, and no reset of the memory array.
`timescale 1ns/1ns
module sebs_eeprom #(
    parameter int WRITE_CYC = sebs_pkg::WRITE_CYCLE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    sebs_bus_if.eeprom bus,
    input wire logic chip_select_pin_2,
    input wire logic chip_select_pin_1,
    input wire logic chip_select_pin_0,
    input wire logic write_protect
);
    import sebs_pkg::*;

    localparam int TW = $clog2(WRITE_CYC + 1);

    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] wp_sync;
    logic scl_d;
    logic sda_d;
    sebs_dev_state_t state;
    logic [1:0] role;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic sda_oe;
    logic rw;
    logic mack;
    logic [ADDR_W-1:0] ptr;
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    logic [7:0] pbuf [0:PAGE_SIZE-1];
    logic [PAGE_SIZE-1:0] pvalid;
    logic busy;
    logic [TW-1:0] timer;
    logic [4:0] cidx;
    logic [PAGE_W-1:0] cpage;
    logic cprot;

    wire scl_s = scl_sync[1];
    wire sda_s = sda_sync[1];
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;
    wire [2:0] cs_pins = {chip_select_pin_2, chip_select_pin_1, chip_select_pin_0};
    // Write-protect register code is not decoded here and is never acknowledged
    wire code_ok = shreg[7:4] == DEV_CODE; // R6
    wire cs_ok = shreg[3:1] == cs_pins; // R7
    wire ctrl_match = code_ok & cs_ok & ~busy; // R3 R15
    wire in_write = (state == ST_RX || state == ST_RX_ACK) && role == ROLE_DATA;
    wire launch = stop_cond & in_write & (|pvalid) & ~busy; // R10
    wire [7:0] rd_byte = mem[ptr]; // R16
    wire commit_step = busy & (cidx != 5'h10);
    wire commit_wr = commit_step & pvalid[cidx[3:0]] & ~cprot; // R11 R21
    wire [3:0] next_low = ptr[3:0] + 4'h1;

    assign bus.sda_oe_dev = sda_oe;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            wp_sync <= 2'h0;
            scl_d <= 1'h1;
            sda_d <= 1'h1;
        end
        else
        begin
            scl_sync <= {scl_sync[0], bus.scl};
            sda_sync <= {sda_sync[0], bus.sda};
            wp_sync <= {wp_sync[0], write_protect};
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // Write cycle: bytes are committed one per clock at its start, the rest is dead time
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            busy <= 1'h0;
            timer <= '0;
            cidx <= 5'h0;
            cpage <= '0;
            cprot <= 1'h0;
        end
        else if (launch)
        begin
            busy <= 1'h1; // R10
            timer <= TW'(WRITE_CYC - 1); // R20
            cidx <= 5'h0;
            cpage <= ptr[7:4];
            cprot <= wp_sync[1]; // R21
        end
        else if (busy)
        begin
            timer <= timer - TW'(1);
            if (timer == '0)
            begin
                busy <= 1'h0; // R20
            end
            if (commit_step)
            begin
                cidx <= cidx + 5'h1;
            end
        end
    end

    // Memory array is not reset
    always_ff @(posedge clk)
    begin
        if (commit_wr)
        begin
            mem[{cpage, cidx[3:0]}] <= pbuf[cidx[3:0]]; // R12
        end
    end

    always_ff @(posedge clk)
    begin
        if (commit_step == 1'h0 && state == ST_RX && scl_fall && bit_cnt == 4'h8
            && role == ROLE_DATA)
        begin
            pbuf[ptr[3:0]] <= shreg; // R13
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            role <= ROLE_CTRL;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            sda_oe <= 1'h0;
            rw <= 1'h0;
            mack <= 1'h0;
            ptr <= '0;
            pvalid <= '0;
        end
        else if (start_cond)
        begin
            state <= ST_RX; // R6
            role <= ROLE_CTRL;
            bit_cnt <= 4'h0;
            sda_oe <= 1'h0;
            if (!busy)
            begin
                pvalid <= '0; // R17
            end
        end
        else if (stop_cond)
        begin
            state <= ST_IDLE;
            sda_oe <= 1'h0;
        end
        else
        begin
            case (state)
                ST_RX:
                begin
                    if (scl_rise && bit_cnt != 4'h8)
                    begin
                        shreg <= {shreg[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    else if (scl_fall && bit_cnt == 4'h8)
                    begin
                        if (role == ROLE_CTRL)
                        begin
                            if (ctrl_match)
                            begin
                                sda_oe <= 1'h1; // R1
                                rw <= shreg[0]; // R8
                                state <= ST_RX_ACK;
                            end
                            else
                            begin
                                state <= ST_IDLE; // R23 R3
                            end
                        end
                        else if (role == ROLE_ADDR)
                        begin
                            ptr <= shreg; // R9
                            sda_oe <= 1'h1; // R1
                            state <= ST_RX_ACK;
                        end
                        else
                        begin
                            pvalid[ptr[3:0]] <= 1'h1; // R12
                            ptr <= {ptr[7:4], next_low}; // R13 R19
                            sda_oe <= 1'h1; // R11
                            state <= ST_RX_ACK;
                        end
                    end
                end
                ST_RX_ACK:
                begin
                    // Held from one falling edge to the next covers the whole high phase
                    if (scl_fall) // R4
                    begin
                        bit_cnt <= 4'h0;
                        if (role == ROLE_CTRL && rw)
                        begin
                            sda_oe <= ~rd_byte[7]; // R16
                            shreg <= {rd_byte[6:0], 1'h0};
                            state <= ST_TX;
                        end
                        else
                        begin
                            sda_oe <= 1'h0;
                            role <= (role == ROLE_CTRL) ? ROLE_ADDR : ROLE_DATA;
                            state <= ST_RX;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_rise)
                    begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (bit_cnt == 4'h8)
                        begin
                            sda_oe <= 1'h0;
                            ptr <= ptr + 8'h01; // R19 R22
                            state <= ST_TX_ACK;
                        end
                        else
                        begin
                            sda_oe <= ~shreg[7];
                            shreg <= {shreg[6:0], 1'h0};
                        end
                    end
                end
                ST_TX_ACK:
                begin
                    if (scl_rise)
                    begin
                        mack <= ~sda_s;
                    end
                    else if (scl_fall)
                    begin
                        bit_cnt <= 4'h0;
                        if (mack)
                        begin
                            sda_oe <= ~rd_byte[7]; // R18
                            shreg <= {rd_byte[6:0], 1'h0};
                            state <= ST_TX;
                        end
                        else
                        begin
                            sda_oe <= 1'h0; // R5
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_IDLE:
                begin
                    sda_oe <= 1'h0;
                end
                default:
                begin
                    state <= ST_IDLE;
                    sda_oe <= 1'h0;
                end
            endcase
        end
    end
endmodule : sebs_eeprom

// >>> sebs_master.sv
// Bus master end: AXI4-Lite command and status registers driving Start, byte and Stop.
// Assumes no clock stretching by the slave; the data line is synchronised before use.
`timescale 1ns/1ns
module sebs_master #(
    parameter int QUARTER = sebs_pkg::SCL_QUARTER_CYC
) (
    input wire logic clk,
    input wire logic rst,
    sebs_bus_if.master bus,
    input wire logic [sebs_pkg::AXI_ADDR_W-1:0] axi_awaddr,
    input wire logic axi_awvalid,
    output logic axi_awready,
    input wire logic [31:0] axi_wdata,
    input wire logic [3:0] axi_wstrb,
    input wire logic axi_wvalid,
    output logic axi_wready,
    output logic [1:0] axi_bresp,
    output logic axi_bvalid,
    input wire logic axi_bready,
    input wire logic [sebs_pkg::AXI_ADDR_W-1:0] axi_araddr,
    input wire logic axi_arvalid,
    output logic axi_arready,
    output logic [31:0] axi_rdata,
    output logic [1:0] axi_rresp,
    output logic axi_rvalid,
    input wire logic axi_rready
);
    import sebs_pkg::*;

    logic aw_held;
    logic w_held;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [1:0] sda_sync;
    sebs_mst_state_t mstate;
    logic [15:0] qcnt;
    logic [1:0] q;
    logic [3:0] bitn;
    logic do_byte;
    logic do_stop;
    logic is_read;
    logic send_nack;
    logic nack_seen;
    logic [7:0] txb;
    logic [7:0] rxb;
    logic scl_oe;
    logic sda_oe;

    wire busy = mstate != M_IDLE;
    wire tick = qcnt == 16'(QUARTER - 1);
    wire sda_s = sda_sync[1];
    wire wr_fire = aw_held & w_held & ~axi_bvalid;
    wire wr_cmd = wr_fire & (aw_addr == CMD_OFF);
    wire wr_known = (aw_addr == CMD_OFF) | (aw_addr == STATUS_OFF);
    wire rd_known = (axi_araddr == CMD_OFF) | (axi_araddr == STATUS_OFF);
    wire [4:0] cmd_flags = w_data[4:0];
    // Commands while busy are dropped, so software polls the busy bit first
    wire cmd_go = wr_cmd & w_strb[0] & ~busy & (|cmd_flags[3:0]);
    wire want_byte = cmd_flags[CMD_WRITE_BIT] | cmd_flags[CMD_READ_BIT];
    wire [31:0] status_word = {16'h0000, rxb, 6'h00, nack_seen, busy};
    wire [31:0] rd_word = (axi_araddr == STATUS_OFF) ? status_word : 32'h00000000;
    wire ack_drive = is_read & ~send_nack;

    assign axi_awready = ~aw_held & ~axi_bvalid;
    assign axi_wready = ~w_held & ~axi_bvalid;
    assign axi_arready = ~axi_rvalid;
    assign bus.scl_oe_mst = scl_oe;
    assign bus.sda_oe_mst = sda_oe;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            aw_held <= 1'h0;
            w_held <= 1'h0;
            aw_addr <= '0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            axi_bvalid <= 1'h0;
            axi_bresp <= RESP_OKAY;
            axi_rvalid <= 1'h0;
            axi_rdata <= 32'h00000000;
            axi_rresp <= RESP_OKAY;
            sda_sync <= 2'h3;
        end
        else
        begin
            sda_sync <= {sda_sync[0], bus.sda};
            if (axi_awvalid && axi_awready)
            begin
                aw_held <= 1'h1;
                aw_addr <= axi_awaddr;
            end
            if (axi_wvalid && axi_wready)
            begin
                w_held <= 1'h1;
                w_data <= axi_wdata;
                w_strb <= axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held <= 1'h0;
                w_held <= 1'h0;
                axi_bvalid <= 1'h1;
                axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (axi_bvalid && axi_bready)
            begin
                axi_bvalid <= 1'h0;
            end
            if (axi_arvalid && axi_arready)
            begin
                axi_rvalid <= 1'h1;
                axi_rdata <= rd_word;
                axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (axi_rvalid && axi_rready)
            begin
                axi_rvalid <= 1'h0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mstate <= M_IDLE;
            qcnt <= 16'h0000;
            q <= 2'h0;
            bitn <= 4'h0;
            do_byte <= 1'h0;
            do_stop <= 1'h0;
            is_read <= 1'h0;
            send_nack <= 1'h0;
            nack_seen <= 1'h0;
            txb <= 8'h00;
            rxb <= 8'h00;
            scl_oe <= 1'h0;
            sda_oe <= 1'h0;
        end
        else if (cmd_go)
        begin
            do_byte <= want_byte;
            do_stop <= cmd_flags[CMD_STOP_BIT];
            is_read <= cmd_flags[CMD_READ_BIT];
            send_nack <= cmd_flags[CMD_NACK_BIT];
            txb <= w_data[15:8];
            nack_seen <= 1'h0;
            qcnt <= 16'h0000;
            q <= 2'h0;
            bitn <= 4'h0;
            if (cmd_flags[CMD_START_BIT])
            begin
                mstate <= M_START;
            end
            else
            begin
                mstate <= want_byte ? M_BIT : M_STOP;
            end
        end
        else if (busy)
        begin
            qcnt <= tick ? 16'h0000 : qcnt + 16'h0001;
            if (tick)
            begin
                q <= q + 2'h1;
                case (mstate)
                    M_START:
                    begin
                        // Release, raise clock, pull data low, then clock low
                        if (q == 2'h0) sda_oe <= 1'h0;
                        if (q == 2'h1) scl_oe <= 1'h0;
                        if (q == 2'h2) sda_oe <= 1'h1;
                        if (q == 2'h3)
                        begin
                            scl_oe <= 1'h1;
                            mstate <= do_byte ? M_BIT : (do_stop ? M_STOP : M_IDLE);
                        end
                    end
                    M_BIT:
                    begin
                        if (q == 2'h0)
                        begin
                            sda_oe <= (bitn == 4'h8) ? ack_drive : (~is_read & ~txb[7]); // R4 R5 R18
                        end
                        if (q == 2'h1) scl_oe <= 1'h0; // R2
                        if (q == 2'h2)
                        begin
                            if (bitn == 4'h8 && !is_read) nack_seen <= sda_s; // R15
                            if (bitn != 4'h8 && is_read) rxb <= {rxb[6:0], sda_s};
                        end
                        if (q == 2'h3)
                        begin
                            scl_oe <= 1'h1;
                            txb <= {txb[6:0], 1'h0};
                            bitn <= bitn + 4'h1;
                            if (bitn == 4'h8)
                            begin
                                mstate <= do_stop ? M_STOP : M_IDLE;
                            end
                        end
                    end
                    M_STOP:
                    begin
                        if (q == 2'h0) sda_oe <= 1'h1;
                        if (q == 2'h1) scl_oe <= 1'h0;
                        if (q == 2'h2) sda_oe <= 1'h0;
                        if (q == 2'h3) mstate <= M_IDLE;
                    end
                    default:
                    begin
                        mstate <= M_IDLE;
                    end
                endcase
            end
        end
    end
endmodule : sebs_master

// >>> sebs_bus_assertions.sv
// Wire checks on the two-wire bus between the master and the EEPROM slave.
// Assumes the shared clock and reset, and the slave's select strap level given as CS.
`timescale 1ns/1ns
module sebs_bus_assertions
    import sebs_pkg::*;
#(
    parameter int WRITE_CYC = 1500,
    parameter logic [2:0] CS = 3'h0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_oe_mst,
    input wire logic sda_oe_mst,
    input wire logic sda_oe_dev,
    input wire logic scl,
    input wire logic sda
);
    logic scl_q;
    logic sda_q;
    logic [3:0] nbit;
    logic [4:0] nbyte;
    logic [7:0] sh;
    logic rd;
    logic ign;
    int cnt;
    wire rise = scl && !scl_q;
    wire start = scl && scl_q && sda_q && !sda;
    wire stop = scl && scl_q && !sda_q && sda;
    wire ninth = rise && nbit == 4'h8;
    wire match = sh[7:4] == DEV_CODE && sh[3:1] == CS;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    always_ff @(posedge clk)
    begin
        scl_q <= rst | scl;
        sda_q <= rst | sda;
        if (rst || start || stop)
        begin
            nbit <= 4'h0;
            nbyte <= 5'h00;
            rd <= 1'b0;
            ign <= !start;
        end
        else if (ninth)
        begin
            nbit <= 4'h0;
            nbyte <= nbyte + 5'h01;
            if (nbyte == 5'h00)
                rd <= sh[0];
            if (sda && (nbyte == 5'h00 || rd))
                ign <= 1'b1;
        end
        else if (rise)
        begin
            sh <= {sh[6:0], sda};
            nbit <= nbit + 4'h1;
        end
    end
    // Margin of 32 covers sync lag and the ack decision ahead of the ninth rise
    always_ff @(posedge clk)
    begin
        if (rst)
            cnt <= 0;
        else if (stop && !rd && !ign && nbyte >= 5'h03)
            cnt <= WRITE_CYC + 32;
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
    chk_dev_stable_high: assert property (scl && scl_q |-> $stable(sda_oe_dev))
        else $error("slave changed data while clock high");
    chk_ack_held: assert property (rise && sda_oe_dev |-> (sda_oe_dev && !sda) [*8])
        else $error("slave low level not held through clock high");
    chk_ctrl_mismatch_nak: assert property (ninth && nbyte == 5'h00 && !match |-> !sda_oe_dev)
        else $error("foreign control byte acknowledged");
    chk_busy_no_ack: assert property (ninth && cnt > 16 |-> !sda_oe_dev)
        else $error("acknowledge during write cycle");
    chk_poll_ack: assert property (ninth && nbyte == 5'h00 && match && cnt == 0 |-> sda_oe_dev)
        else $error("matching control byte not acknowledged after write cycle");
    chk_write_ack: assert property (ninth && nbyte != 5'h00 && !rd && !ign |-> sda_oe_dev)
        else $error("written byte not acknowledged");
    chk_ignore_quiet: assert property (ign |-> !sda_oe_dev)
        else $error("slave drove data while ignoring the bus");
    chk_read_release: assert property (ninth && rd && nbyte != 5'h00 |-> !sda_oe_dev)
        else $error("slave drove data in master acknowledge slot");
    cov_mismatch: cover property (ninth && nbyte == 5'h00 && !match);
    cov_cycle_end: cover property (cnt == 1);
    cov_read_nak: cover property (ninth && rd && nbyte != 5'h00 && sda);
endmodule : sebs_bus_assertions

// >>> sebs_tb.sv
// Testbench: AXI4-Lite driven master against the EEPROM slave on one bus.
// Assumes shortened bit and write-cycle times set through the parameters below.
`timescale 1ns/1ns
module sebs_tb;
    import sebs_pkg::*;
    localparam int WCYC = 1500;
    localparam int QT = 8;
    localparam logic [2:0] CS = 3'h5;
    localparam logic [7:0] CW = {DEV_CODE, CS, 1'b0};
    localparam logic [7:0] CR = {DEV_CODE, CS, 1'b1};
    localparam logic [4:0] FS = 5'h01, FW = 5'h02, FR = 5'h04, FP = 5'h08, FN = 5'h10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wp = 1'b0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, st;
    int n_errors = 0;
    int samples_checked = 0;
    sebs_bus_if bus ();
    always #5 clk = ~clk;
    sebs_eeprom #(.WRITE_CYC(WCYC)) sebs_eeprom_i (.clk(clk), .rst(rst), .bus(bus.eeprom),
        .chip_select_pin_2(CS[2]), .chip_select_pin_1(CS[1]), .chip_select_pin_0(CS[0]),
        .write_protect(wp));
    // Ready lines held high: the responses are always taken at once
    sebs_master #(.QUARTER(QT)) sebs_master_i (.clk(clk), .rst(rst), .bus(bus.master),
        .axi_awaddr(awaddr), .axi_awvalid(awvalid), .axi_awready(awready), .axi_wdata(wdata),
        .axi_wstrb(wstrb), .axi_wvalid(wvalid), .axi_wready(wready), .axi_bresp(bresp),
        .axi_bvalid(bvalid), .axi_bready(1'b1), .axi_araddr(araddr), .axi_arvalid(arvalid),
        .axi_arready(arready), .axi_rdata(rdata), .axi_rresp(rresp), .axi_rvalid(rvalid),
        .axi_rready(1'b1));
    sebs_bus_assertions #(.WRITE_CYC(WCYC), .CS(CS)) sebs_bus_assertions_i (.clk(clk),
        .rst(rst), .scl_oe_mst(bus.scl_oe_mst), .sda_oe_mst(bus.sda_oe_mst),
        .sda_oe_dev(bus.sda_oe_dev), .scl(bus.scl), .sda(bus.sda));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
    endtask : axw
    task automatic axr(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        st = rdata;
    endtask : axr
    // One bus step; status polled until the master goes idle
    task automatic xfer(input logic [4:0] f, input logic [7:0] b);
        axw(CMD_OFF, {16'h0000, b, 3'h0, f});
        do
            axr(STATUS_OFF);
        while (st[STAT_BUSY_BIT] !== 1'b0);
    endtask : xfer
    task automatic wb(input logic [4:0] f, input logic [7:0] b, input logic nak);
        xfer(f, b);
        check(st[STAT_NACK_BIT], nak);
    endtask : wb
    task automatic rb(input logic [4:0] f, input logic [7:0] exp);
        xfer(f, 8'h00);
        check(st[15:8], exp);
    endtask : rb
    task automatic seek(input logic [7:0] a);
        wb(FS | FW, CW, 1'b0);
        wb(FW, a, 1'b0);
    endtask : seek
    task automatic poll;
        int n;
        n = 0;
        do
        begin
            xfer(FS | FW | FP, CW);
            n++;
        end
        while (st[STAT_NACK_BIT] !== 1'b0 && n < 40);
        check(st[STAT_NACK_BIT], 1'b0);
        check(n > 1, 1'b1);
        check(n <= WCYC / (44 * QT) + 2, 1'b1);
    endtask : poll
    task automatic wr1(input logic [7:0] a, input logic [7:0] d);
        seek(a);
        wb(FW, d, 1'b0);
        xfer(FP, 8'h00);
        poll();
    endtask : wr1
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        axr(4'h8);
        check(rresp, RESP_SLVERR);
        wb(FS | FW | FP, {4'h6, CS, 1'b0}, 1'b1);
        wb(FS | FW | FP, {DEV_CODE, 3'h4, 1'b0}, 1'b1);
        wb(FS | FW | FP, CW, 1'b0);
        $display("select test done");
        seek(8'h1E);
        for (int i = 0; i < 17; i++)
            wb(FW, 8'h40 + 8'(i), 1'b0);
        xfer(FP, 8'h00);
        poll();
        $display("page test done");
        seek(8'h1C);
        wb(FS | FW, CR, 1'b0);
        rb(FR, 8'h4E);
        rb(FR, 8'h4F);
        rb(FR | FN | FP, 8'h50);
        wb(FS | FW, CR, 1'b0);
        rb(FR | FN | FP, 8'h41);
        $display("read test done");
        wp <= 1'b1;
        wr1(8'h10, 8'hAA);
        wp <= 1'b0;
        seek(8'h10);
        wb(FS | FW, CR, 1'b0);
        rb(FR | FN | FP, 8'h42);
        $display("protect test done");
        wr1(8'hFF, 8'h33);
        wr1(8'h00, 8'h5A);
        seek(8'hFF);
        wb(FS | FW, CR, 1'b0);
        rb(FR, 8'h33);
        rb(FR | FN | FP, 8'h5A);
        $display("wrap test done");
        test_done();
    end
    initial
    begin
        repeat (90000) @(posedge clk);
        n_errors++;
        test_done();
    end
endmodule : sebs_tb
